// ### isa_rcg_pkg.sv
/*
 Constants, register indices and helper functions for the reset and clock unit.
 Assumes a 20 MHz host clock and 32-bit classic Wishbone register access.
*/
package isa_rcg_pkg;
    localparam int unsigned SYS_CLK_HZ = 20_000_000;
    // Backplane divider codes map to ratios 2,3,4,5,6,8
    localparam logic [2:0] RATIO_SEL_RST = 3'h0;
    localparam int unsigned OSC_DIV = 12;
    localparam logic [2:0] OSC_HALF_M1 = 3'h5;
    // Backplane reset held more than 80 host clocks
    localparam int unsigned BP_HOLD_HCLK = 80;
    localparam logic [6:0] BP_HOLD_CYC = 7'(BP_HOLD_HCLK + 1);
    localparam int unsigned CPU_RST_NS = 800;
    localparam logic [4:0] CPU_RST_CYC = 5'((CPU_RST_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000);
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h00;
    localparam logic [7:0] IDX_RATIO = 8'h01;
    localparam logic [7:0] IDX_DMA = 8'h06;
    localparam logic [7:0] IDX_SYS_CTL = 8'h92;
    localparam logic [7:0] IDX_COP_EN = 8'hf0;
    localparam logic [7:0] IDX_COP_RST = 8'hf1;
    localparam int unsigned FAST_RST_BIT = 0;
    localparam int unsigned DMA_HALF_BIT = 0;
    localparam int unsigned COP_EN_BIT = 0;
    localparam logic COP_EN_RST = 1'b1;
    localparam logic DMA_HALF_RST = 1'b0;
    localparam int unsigned ST_CPU_BIT = 4;
    localparam int unsigned ST_COP_BIT = 5;
    localparam int unsigned ST_BP_BIT = 6;
    localparam int unsigned ST_REV_BIT = 7;

    function automatic logic [3:0] ratio_of(input logic [2:0] code);
        case (code)
            3'h0: ratio_of = 4'h2;
            3'h1: ratio_of = 4'h3;
            3'h2: ratio_of = 4'h4;
            3'h3: ratio_of = 4'h5;
            3'h4: ratio_of = 4'h6;
            default: ratio_of = 4'h8;
        endcase
    endfunction

    function automatic logic [3:0] high_len(input logic [2:0] code);
        logic [3:0] r;
        r = ratio_of(code);
        high_len = 4'((r + 4'h1) >> 1);
    endfunction
endpackage

// ### bclk_if.sv
/*
 Carries the divider selection and backplane clock between the top and divider.
 Assumes both ends run on the host clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface bclk_if;
    logic [2:0] ratio_sel;
    logic bclk;
    logic bclk_rise;
    modport gen (input ratio_sel, output bclk, output bclk_rise);
    modport user (output ratio_sel, input bclk, input bclk_rise);
endinterface
`default_nettype wire

// ### pin_sync.sv
/*
 Three-flop synchroniser for pin inputs with agreement filter.
 Assumes inputs are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] lvl_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lvl_q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    lvl_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### bclk_div.sv
/*
 Programmable backplane clock divider, ratios 2,3,4,5,6,8.
 Assumes ratio_sel may change at any time; it is taken at the period boundary.
*/
`timescale 1ns/1ps
`default_nettype none
module bclk_div
    import isa_rcg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    bclk_if.gen bif
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [2:0] cur_q;
    logic wrap;

    assign wrap = (cnt_q == 4'(ratio_of(cur_q) - 4'h1));
    assign cnt_d = wrap ? 4'h0 : 4'(cnt_q + 4'h1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d; // [RULE1]
        end
    end

    // New ratio only at a boundary, so no runt pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_q <= RATIO_SEL_RST;
        end else if (wrap) begin
            cur_q <= bif.ratio_sel; // [RULE14]
        end
    end

    // Odd ratios run one host clock longer high; one clock edge only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bif.bclk <= 1'b0;
            bif.bclk_rise <= 1'b0;
        end else begin
            bif.bclk <= wrap || (cnt_d < high_len(cur_q)); // [RULE2]
            bif.bclk_rise <= wrap;
        end
    end

    count_bound_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE1]
        cnt_q < ratio_of(cur_q))
        else $error("divider count beyond ratio");
    ratio_change_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE14]
        $changed(cur_q) |-> cnt_q == 4'h0)
        else $error("ratio changed mid period");
    div_two_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
        ($rose(bif.bclk) && cur_q == 3'h0 && $stable(cur_q)) |=> !bif.bclk ##1 bif.bclk)
        else $error("divide by two not 50 percent");
endmodule
`default_nettype wire

// ### isa_rcg_top.sv
/*
 Reset and clock generation for an ISA bus controller: backplane, DMA and
 timer clocks; CPU, coprocessor and backplane resets; Wishbone registers.
 Assumes a 20 MHz host clock, pins asynchronous to it, a classic Wishbone master.
*/
// The placing of the registers and the Wishbone register port were left to the implementer.
// Functional notes
// RULE1: Backplane clock divides host by 2,3,4,5,6,8.
// RULE2: Backplane clock near 50 percent duty.
// RULE3: All state machines run on host clock.
// RULE4: DMA clock is bus clock or half.
// RULE5: Timer clock is oscillator divided by twelve.
// RULE6: Power-on reset clears all, asserts three resets.
// RULE7: CPU reset generated synchronous to host clock.
// RULE8: Keyboard input or fast bit resets CPU.
// RULE9: Coprocessor reset from power-on or port write.
// RULE10: Coprocessor port reset enabled after power-on.
// RULE11: Backplane reset on bus clock, power-on only.
// RULE12: Backplane reset held over 80 clocks after release.
// RULE13: Later revisions also assert during power-on.
// RULE14: Divider change applied at period boundary.
`timescale 1ns/1ps
`default_nettype none
module isa_rcg_top
    import isa_rcg_pkg::*;
#(
    parameter bit LATE_REV = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic power_on_reset_in,
    input wire logic keyboard_reset_in,
    input wire logic osc_in,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic bus_clk_out,
    output logic dma_clk_out,
    output logic timer_clk_out,
    output logic cpu_reset_out,
    output logic coproc_reset_out,
    output logic backplane_reset_out
);
    bclk_if bif ();

    logic por_s;
    logic kb_s;
    logic osc_s;
    logic por_prev_q;
    logic kb_prev_q;
    logic osc_prev_q;
    logic por_fall;
    logic kb_rise;
    logic osc_rise;

    logic [2:0] ratio_sel_q;
    logic dma_half_q;
    logic fast_reset_bit;
    logic cop_en_q;
    logic fast_rise;
    logic cop_req;

    logic [4:0] cpu_cnt_q;
    logic [4:0] cop_cnt_q;
    logic [6:0] hold_cnt_q;
    logic bp_req;
    logic [2:0] osc_cnt_q;

    logic [7:0] idx;
    logic hit_hi;
    logic acc;
    logic wr_commit;

    // Single host clock drives all logic below
    bclk_div u_div ( // [RULE3]
        .sys_clk(sys_clk),
        .rst(rst),
        .bif(bif)
    );

    pin_sync #(.W(3)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin({osc_in, keyboard_reset_in, power_on_reset_in}),
        .lvl_q({osc_s, kb_s, por_s})
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            por_prev_q <= 1'b0;
            kb_prev_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            por_prev_q <= por_s;
            kb_prev_q <= kb_s;
            osc_prev_q <= osc_s;
        end
    end

    assign por_fall = por_prev_q && !por_s;
    assign kb_rise = kb_s && !kb_prev_q;
    assign osc_rise = osc_s && !osc_prev_q;

    // Register access: index in bits 9:2, upper address bits must be zero
    assign idx = wb_adr_i[9:2];
    assign hit_hi = (wb_adr_i[11:10] == 2'h0);
    assign acc = wb_cyc_i && wb_stb_i;
    // Write lands on the edge where the master sees ack
    assign wr_commit = acc && wb_ack_o && wb_we_i && wb_sel_i[0] && hit_hi;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc && !wb_ack_o;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (acc && !wb_ack_o) begin
            wb_dat_o <= '0;
            if (hit_hi) begin
                case (idx)
                    IDX_STATUS: begin
                        wb_dat_o[2:0] <= ratio_sel_q;
                        wb_dat_o[3] <= dma_half_q;
                        wb_dat_o[ST_CPU_BIT] <= cpu_reset_out;
                        wb_dat_o[ST_COP_BIT] <= coproc_reset_out;
                        wb_dat_o[ST_BP_BIT] <= backplane_reset_out;
                        wb_dat_o[ST_REV_BIT] <= LATE_REV;
                    end
                    IDX_RATIO: wb_dat_o[2:0] <= ratio_sel_q;
                    IDX_DMA: wb_dat_o[DMA_HALF_BIT] <= dma_half_q;
                    IDX_SYS_CTL: wb_dat_o[FAST_RST_BIT] <= fast_reset_bit;
                    IDX_COP_EN: wb_dat_o[COP_EN_BIT] <= cop_en_q;
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    // Configuration returns to defaults while power-on reset is high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ratio_sel_q <= RATIO_SEL_RST;
        end else if (por_s) begin
            ratio_sel_q <= RATIO_SEL_RST; // [RULE6]
        end else if (wr_commit && idx == IDX_RATIO) begin
            ratio_sel_q <= wb_dat_i[2:0]; // [RULE1]
        end
    end

    assign bif.ratio_sel = ratio_sel_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dma_half_q <= DMA_HALF_RST;
        end else if (por_s) begin
            dma_half_q <= DMA_HALF_RST; // [RULE6]
        end else if (wr_commit && idx == IDX_DMA) begin
            dma_half_q <= wb_dat_i[DMA_HALF_BIT]; // [RULE4]
        end
    end

    // Fast reset fires on a 0 to 1 write of the bit
    assign fast_rise = wr_commit && idx == IDX_SYS_CTL && wb_dat_i[FAST_RST_BIT] && !fast_reset_bit;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fast_reset_bit <= 1'b0;
        end else if (por_s) begin
            fast_reset_bit <= 1'b0;
        end else if (wr_commit && idx == IDX_SYS_CTL) begin
            fast_reset_bit <= wb_dat_i[FAST_RST_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cop_en_q <= COP_EN_RST;
        end else if (por_s) begin
            cop_en_q <= COP_EN_RST; // [RULE10]
        end else if (wr_commit && idx == IDX_COP_EN) begin
            cop_en_q <= wb_dat_i[COP_EN_BIT];
        end
    end

    // While cop_en_q is set, any data written to the coprocessor port pulses its reset
    assign cop_req = wr_commit && idx == IDX_COP_RST && cop_en_q; // [RULE9]

    // CPU reset: power-on, keyboard pin or fast bit; stretched by counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpu_cnt_q <= '0;
        end else if (por_s || kb_rise || fast_rise) begin
            cpu_cnt_q <= CPU_RST_CYC; // [RULE8]
        end else if (cpu_cnt_q != 5'h0) begin
            cpu_cnt_q <= cpu_cnt_q - 5'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpu_reset_out <= 1'b1;
        end else begin
            cpu_reset_out <= por_s || (cpu_cnt_q != 5'h0); // [RULE6] [RULE7]
        end
    end

    // Coprocessor reset shares the CPU timing; keyboard paths excluded
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cop_cnt_q <= '0;
        end else if (por_s || cop_req) begin
            cop_cnt_q <= CPU_RST_CYC; // [RULE9]
        end else if (cop_cnt_q != 5'h0) begin
            cop_cnt_q <= cop_cnt_q - 5'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            coproc_reset_out <= 1'b1;
        end else begin
            coproc_reset_out <= por_s || (cop_cnt_q != 5'h0); // [RULE6] [RULE9]
        end
    end

    // Backplane hold starts at power-on release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_cnt_q <= '0;
        end else if (por_s) begin
            hold_cnt_q <= '0;
        end else if (por_fall) begin
            hold_cnt_q <= BP_HOLD_CYC; // [RULE12]
        end else if (hold_cnt_q != 7'h0) begin
            hold_cnt_q <= hold_cnt_q - 7'h1;
        end
    end

    assign bp_req = (LATE_REV && por_s) || por_fall || (hold_cnt_q != 7'h0); // [RULE13]

    // Updated only at bus clock rise; keyboard paths never reach it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            backplane_reset_out <= 1'b1;
        end else if (bif.bclk_rise) begin
            backplane_reset_out <= bp_req; // [RULE11]
        end
    end

    // Outputs delayed one cycle so both clocks leave from flops together
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_clk_out <= 1'b0;
        end else begin
            bus_clk_out <= bif.bclk;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dma_clk_out <= 1'b0;
        end else if (!dma_half_q) begin
            dma_clk_out <= bif.bclk; // [RULE4]
        end else if (bif.bclk_rise) begin
            dma_clk_out <= !dma_clk_out; // [RULE4]
        end
    end

    // Oscillator sampled by host clock: filter needs two equal samples per level, so host at least four times its rate
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_cnt_q <= '0;
            timer_clk_out <= 1'b0;
        end else if (osc_rise) begin
            if (osc_cnt_q == OSC_HALF_M1) begin
                osc_cnt_q <= '0;
                timer_clk_out <= !timer_clk_out; // [RULE5]
            end else begin
                osc_cnt_q <= osc_cnt_q + 3'h1;
            end
        end
    end

    // Helper for hold check: host cycles since power-on release
    // Starts saturated: a plain reset owes no power-on hold
    logic [7:0] since_por_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            since_por_q <= 8'hff;
        end else if (por_s) begin
            since_por_q <= '0;
        end else if (since_por_q != 8'hff) begin
            since_por_q <= since_por_q + 8'h1;
        end
    end

    sequence cop_port_write;
        wr_commit && idx == IDX_COP_RST && cop_en_q;
    endsequence

    sequence por_seen;
        por_s ##1 por_s;
    endsequence

    por_resets_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE6]
        por_seen |=> cpu_reset_out && coproc_reset_out)
        else $error("power-on did not assert resets");
    kb_reset_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE8]
        (kb_rise || fast_rise) |=> ##1 cpu_reset_out [*8])
        else $error("keyboard reset pulse too short");
    cop_write_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
        cop_port_write |=> ##1 coproc_reset_out [*8])
        else $error("coprocessor port write no reset");
    cop_cause_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
        $rose(coproc_reset_out) |-> $past(por_s, 1) || $past(wr_commit && idx == IDX_COP_RST, 2))
        else $error("coprocessor reset without cause");
    bp_sync_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE11]
        $changed(backplane_reset_out) |-> $past(bif.bclk_rise))
        else $error("backplane reset off bus clock");
    bp_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE12]
        ($fell(backplane_reset_out) && !por_s) |-> since_por_q > 8'(BP_HOLD_HCLK))
        else $error("backplane reset hold too short");
    dma_direct_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE4]
        $past(!dma_half_q) |-> dma_clk_out == $past(bif.bclk))
        else $error("direct dma clock mismatch");
    timer_div_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE5]
        $changed(timer_clk_out) |-> $past(osc_rise && osc_cnt_q == OSC_HALF_M1))
        else $error("timer clock toggled off count");
    ack_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// ### board_model.sv
/*
 Board-side partner: backplane oscillator and keyboard reset request source.
 Assumes sys_clk is the host clock; the oscillator runs no faster than sys_clk/4.
*/
`timescale 1ns/1ps
`default_nettype none
module board_model #(
    parameter int OSC_HALF = 2
) (
    input wire logic sys_clk,
    input wire logic kbd_req,
    output logic osc_in,
    output logic keyboard_reset_in
);
    int osc_cnt;
    int kbd_cnt;
    logic kbd_req_q;

    initial begin
        osc_in = 1'b0;
        keyboard_reset_in = 1'b0;
        osc_cnt = 0;
        kbd_cnt = 0;
        kbd_req_q = 1'b0;
    end

    // Real oscillator outruns the host sampler, so it is slowed here
    always @(posedge sys_clk) begin
        if (osc_cnt == OSC_HALF - 1) begin
            osc_in <= ~osc_in;
            osc_cnt <= 0;
        end else begin
            osc_cnt <= osc_cnt + 1;
        end
    end

    // Request held several host cycles so the pin synchroniser sees it
    always @(posedge sys_clk) begin
        kbd_req_q <= kbd_req;
        if (kbd_req && !kbd_req_q) begin
            kbd_cnt <= 4;
        end else if (kbd_cnt != 0) begin
            kbd_cnt <= kbd_cnt - 1;
        end
        keyboard_reset_in <= (kbd_req && !kbd_req_q) || (kbd_cnt > 1);
    end
endmodule
`default_nettype wire

// ### testbench.sv
/*
 Self-checking bench for the reset and clock unit, registers over Wishbone.
 Assumes a 20 MHz host clock and the board_model partner for osc and keyboard.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
    import isa_rcg_pkg::*;
;
    localparam int LIMIT = 20000;
    localparam int RATIO [8] = '{2, 3, 4, 5, 6, 8, 8, 8};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic power_on_reset_in = 1'b0;
    logic kbd_req = 1'b0;
    logic keyboard_reset_in, osc_in;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, bus_clk_out, dma_clk_out, timer_clk_out;
    logic cpu_reset_out, coproc_reset_out, backplane_reset_out;
    logic seen_cpu = 1'b0;
    logic seen_cop = 1'b0;
    logic seen_bp = 1'b0;
    logic dma_diff = 1'b0;
    logic watch_dma = 1'b0;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int hi, per, lat, len;

    always #25 sys_clk = ~sys_clk;

    isa_rcg_top #(.LATE_REV(1'b1)) i_isa_rcg_top (.sys_clk(sys_clk), .rst(rst),
        .power_on_reset_in(power_on_reset_in), .keyboard_reset_in(keyboard_reset_in), .osc_in(osc_in),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .bus_clk_out(bus_clk_out), .dma_clk_out(dma_clk_out), .timer_clk_out(timer_clk_out),
        .cpu_reset_out(cpu_reset_out), .coproc_reset_out(coproc_reset_out),
        .backplane_reset_out(backplane_reset_out));

    board_model i_board_model (.sys_clk(sys_clk), .kbd_req(kbd_req), .osc_in(osc_in),
        .keyboard_reset_in(keyboard_reset_in));

    // Sticky watchers, sampled mid-cycle where registered outputs are settled
    always @(negedge sys_clk) begin
        // Blocking, so a clear from the test at this edge cannot be undone
        seen_cpu = seen_cpu | cpu_reset_out;
        seen_cop = seen_cop | coproc_reset_out;
        seen_bp = seen_bp | backplane_reset_out;
        if (watch_dma && dma_clk_out !== bus_clk_out) begin
            dma_diff = 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors = errors + 1;
            final_report();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wb_cycle(input logic [7:0] idx, input logic we, input logic [7:0] wd, output logic [31:0] data);
        int n;
        @(posedge sys_clk);
        wb_adr_i <= {2'b00, idx, 2'b00};
        wb_dat_i <= {24'h0, wd};
        wb_we_i <= we;
        wb_sel_i <= 4'hf;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        data = wb_dat_o;
        check("wb ack", {31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        wb_cycle(idx, 1'b1, d, x);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        wb_cycle(idx, 1'b0, 8'h00, x);
        check(name, x, exp);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: pick = bus_clk_out;
            1: pick = dma_clk_out;
            2: pick = timer_clk_out;
            3: pick = cpu_reset_out;
            default: pick = coproc_reset_out;
        endcase
    endfunction

    // One full period from a rising edge, in host cycles
    task automatic measure(input int s, output int hi_n, output int per_n);
        int n;
        n = 0;
        hi_n = 0;
        per_n = 0;
        @(negedge sys_clk);
        while (pick(s) !== 1'b0 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        while (pick(s) !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        while (pick(s) === 1'b1 && per_n < 200) begin
            @(negedge sys_clk);
            hi_n++;
            per_n++;
        end
        while (pick(s) === 1'b0 && per_n < 400) begin
            @(negedge sys_clk);
            per_n++;
        end
    endtask

    task automatic pulse(input int s, output int lat_n, output int len_n);
        lat_n = 0;
        len_n = 0;
        @(negedge sys_clk);
        while (pick(s) !== 1'b1 && lat_n < 200) begin
            @(negedge sys_clk);
            lat_n++;
        end
        while (pick(s) === 1'b1 && len_n < 300) begin
            @(negedge sys_clk);
            len_n++;
        end
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rd_chk("status", IDX_STATUS, 32'h1 << ST_REV_BIT);
        rd_chk("ratio", IDX_RATIO, 32'h0);
        rd_chk("dma", IDX_DMA, 32'h0);
        rd_chk("cop en", IDX_COP_EN, 32'h1);
        rd_chk("cop port", IDX_COP_RST, 32'h0);
        rd_chk("unmapped", 8'h33, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wr(IDX_RATIO, 8'(c));
            // Old period may still be running; the new ratio waits for its wrap
            repeat (8) @(posedge sys_clk);
            measure(0, hi, per);
            check("bus period first", per, RATIO[c]);
            measure(0, hi, per);
            check("bus period", per, RATIO[c]);
            check("bus high", hi, (RATIO[c] + 1) / 2);
            rd_chk("ratio", IDX_RATIO, 32'(c));
        end
        wr(IDX_RATIO, 8'h02);
        watch_dma = 1'b1;
        repeat (40) @(posedge sys_clk);
        watch_dma = 1'b0;
        check("dma direct", {31'h0, dma_diff}, 32'h0);
        wr(IDX_DMA, 8'h01);
        measure(1, hi, per);
        measure(1, hi, per);
        check("dma half period", per, 8);
        rd_chk("dma", IDX_DMA, 32'h1);
        measure(2, hi, per);
        check("timer period", per, 48);
        seen_cop = 1'b0;
        seen_bp = 1'b0;
        wr(IDX_SYS_CTL, 8'h01);
        pulse(3, lat, len);
        check("fast lat", lat, 1);
        check("fast len", len, 16);
        // Fast bit acts on a 0 to 1 change only
        seen_cpu = 1'b0;
        wr(IDX_SYS_CTL, 8'h01);
        repeat (20) @(posedge sys_clk);
        check("fast again", {31'h0, seen_cpu}, 32'h0);
        wr(IDX_SYS_CTL, 8'h00);
        wr(IDX_SYS_CTL, 8'h01);
        pulse(3, lat, len);
        check("fast len 2", len, 16);
        @(posedge sys_clk);
        kbd_req <= 1'b1;
        pulse(3, lat, len);
        kbd_req <= 1'b0;
        check("kbd len", len, 16);
        check("kbd lat", 32'(lat inside {[1:10]}), 32'h1);
        check("no bp", {31'h0, seen_bp}, 32'h0);
        check("no cop", {31'h0, seen_cop}, 32'h0);
        seen_cpu = 1'b0;
        wr(IDX_COP_RST, 8'h00);
        pulse(4, lat, len);
        check("cop lat", lat, 1);
        check("cop len", len, 16);
        check("cop not cpu", {31'h0, seen_cpu}, 32'h0);
        wr(IDX_COP_EN, 8'h00);
        rd_chk("cop en off", IDX_COP_EN, 32'h0);
        seen_cop = 1'b0;
        wr(IDX_COP_RST, 8'h00);
        repeat (20) @(posedge sys_clk);
        check("cop disabled", {31'h0, seen_cop}, 32'h0);
        wr(IDX_RATIO, 8'h03);
        @(posedge sys_clk);
        power_on_reset_in <= 1'b1;
        repeat (30) @(posedge sys_clk);
        @(negedge sys_clk);
        check("por resets", {29'h0, cpu_reset_out, coproc_reset_out, backplane_reset_out}, 32'h7);
        @(posedge sys_clk);
        power_on_reset_in <= 1'b0;
        lat = 0;
        len = 0;
        for (int n = 1; n <= 150; n++) begin
            @(negedge sys_clk);
            if (lat == 0 && cpu_reset_out === 1'b0) lat = n;
            if (len == 0 && backplane_reset_out === 1'b0) len = n;
        end
        check("cpu release", 32'(lat inside {[16:28]}), 32'h1);
        check("bp hold", 32'(len inside {[82:100]}), 32'h1);
        rd_chk("ratio por", IDX_RATIO, 32'h0);
        rd_chk("dma por", IDX_DMA, 32'h0);
        rd_chk("cop en por", IDX_COP_EN, 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
